// >>> design/ltal_consts.vh
// ltal_consts.vh: constants for the light threshold alert logic
// assumes inclusion by design files that use these names; definitions only
`ifndef LTAL_CONSTS_VH
`define LTAL_CONSTS_VH

// register offsets on the plain register port
`define LTAL_ADDR_W 4
`define LTAL_OFS_CONFIG 4'h0
`define LTAL_OFS_HIGH_LIMIT 4'h1
`define LTAL_OFS_LOW_LIMIT 4'h2
`define LTAL_OFS_IRQ_STATUS 4'h3
`define LTAL_OFS_IRQ_CLEAR 4'h4
`define LTAL_OFS_IRQ_ENABLE 4'h5
`define LTAL_OFS_RESULT 4'h6

// configuration field positions
`define LTAL_CFG_FAULT_LSB 0
`define LTAL_CFG_FAULT_MSB 1
`define LTAL_CFG_SENSE_BIT 3
`define LTAL_CFG_LATCH_BIT 4
`define LTAL_CFG_CRDY_BIT 7
`define LTAL_CFG_FLOW_BIT 5
`define LTAL_CFG_FHIGH_BIT 6
`define LTAL_CFG_MODE_LSB 9
`define LTAL_CFG_MODE_MSB 10
`define LTAL_CFG_RESET 16'h0010
`define LTAL_MODE_SHUTDOWN 2'h0

// end-of-conversion marker in the low limit top bits
`define LTAL_EOC_CODE 2'h3

// interrupt status bit positions
`define LTAL_IRQ_HIGH 0
`define LTAL_IRQ_LOW 1
`define LTAL_IRQ_DONE 2
`define LTAL_IRQ_W 3

`endif

// >>> design/ltal_alert.v
// ltal_alert.v: threshold comparison, fault counting, flags and alert pin
// assumes conversion results arrive as a one-cycle strobe on clk and that
// the alert response completion arrives on its own pin from the serial side
// and that an external pull-up sets the alert line level when released
`timescale 1ns/100ps
`include "ltal_consts.vh"

module ltal_alert #(
  parameter DATA_W = 16
)
(
  input wire clk,
  input wire reset,
  input wire [`LTAL_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  input wire conv_done,
  input wire [DATA_W-1:0] conv_result,
  input wire alert_resp_pin,
  output wire alert_pin_out,
  output wire alert_pin_oe,
  input wire alert_pin_in,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////
  // configuration and limits
  reg [15:0] config_bits;
  reg [DATA_W-1:0] high_limit;
  reg [DATA_W-1:0] low_limit;
  reg [DATA_W-1:0] last_result;
  reg flag_high;
  reg flag_low;
  reg conv_ready;
  reg alert_active;
  reg [`LTAL_IRQ_W-1:0] irq_status;
  reg [`LTAL_IRQ_W-1:0] irq_enable;
  reg resp_meta;
  reg resp_sync;
  reg resp_prev;
  reg pin_meta;
  reg pin_sync;

  wire latch_mode = config_bits[`LTAL_CFG_LATCH_BIT];
  wire sense_sel = config_bits[`LTAL_CFG_SENSE_BIT];
  wire [1:0] fault_sel = config_bits[`LTAL_CFG_FAULT_MSB:`LTAL_CFG_FAULT_LSB];
  wire [1:0] exponent_top_bits = low_limit[DATA_W-1:DATA_W-2];
  wire eoc_mode = (exponent_top_bits == `LTAL_EOC_CODE);

  wire cfg_sel = (reg_addr == `LTAL_OFS_CONFIG);
  wire cfg_read = reg_read && cfg_sel;
  wire cfg_write = reg_write && cfg_sel;
  wire [1:0] wr_mode = reg_wdata[`LTAL_CFG_MODE_MSB:`LTAL_CFG_MODE_LSB];
  wire wr_run = (wr_mode != `LTAL_MODE_SHUTDOWN);

  // fault count field: 0,1,2,3 select 1,2,4,8 consecutive conversions
  reg [3:0] need;
  always @*
  begin
    case (fault_sel)
      2'h0: need = 4'h1;
      2'h1: need = 4'h2;
      2'h2: need = 4'h4;
      default: need = 4'h8;
    endcase
  end

  // run counters saturate at 15, so a fault that persists fires again
  // on every later conversion instead of wrapping back to a pass
  reg [3:0] high_run;
  reg [3:0] low_run;
  reg [3:0] next_high_run;
  reg [3:0] next_low_run;
  wire above = conv_result > high_limit;
  wire below = conv_result < low_limit;
  always @*
  begin
    next_high_run = 4'h0;
    next_low_run = 4'h0;
    if (above)
      next_high_run = (high_run == 4'hf) ? high_run : high_run + 4'h1;
    if (below)
      next_low_run = (low_run == 4'hf) ? low_run : low_run + 4'h1;
  end
  wire high_hit = conv_done && above && (next_high_run >= need);
  wire low_hit = conv_done && below && (next_low_run >= need);

  // alert response edge; first sync stage read by the second only
  wire resp_event = resp_sync && !resp_prev;
  wire resp_take = resp_event && latch_mode;

  // status clear requests from config accesses
  // reads and non-shutdown writes drop ready in every mode
  wire ready_clear = cfg_read || (cfg_write && wr_run);
  // only latched mode lets a read wipe the flags; this term wipes the alert with them
  wire flag_clear = latch_mode && cfg_read;
  // transparent end-of-conversion drops the alert on read or run write
  wire eoc_clear = eoc_mode && !latch_mode && (cfg_read || (cfg_write && wr_run));

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for pins from outside the clock domain
  // both pins are asynchronous, so two stages come before any decode
  always @(posedge clk)
  begin
    if (reset)
    begin
      resp_meta <= 1'b0;
      resp_sync <= 1'b0;
      resp_prev <= 1'b0;
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end
    else
    begin
      resp_meta <= alert_resp_pin;
      resp_sync <= resp_meta;
      resp_prev <= resp_sync;
      pin_meta <= alert_pin_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // consecutive fault counters, one per direction
  always @(posedge clk)
  begin
    if (reset)
    begin
      high_run <= 4'h0;
      low_run <= 4'h0;
      last_result <= {DATA_W{1'b0}};
    end
    else if (conv_done)
    begin
      high_run <= next_high_run;
      low_run <= next_low_run;
      last_result <= conv_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers written by software
  // limits apply from the next conversion; past runs are not judged again
  always @(posedge clk)
  begin
    if (reset)
    begin
      config_bits <= `LTAL_CFG_RESET;
      high_limit <= {DATA_W{1'b1}};
      low_limit <= {DATA_W{1'b0}};
      irq_enable <= {`LTAL_IRQ_W{1'b0}};
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `LTAL_OFS_CONFIG: config_bits <= reg_wdata;
        `LTAL_OFS_HIGH_LIMIT: high_limit <= reg_wdata[DATA_W-1:0];
        `LTAL_OFS_LOW_LIMIT: low_limit <= reg_wdata[DATA_W-1:0];
        `LTAL_OFS_IRQ_ENABLE: irq_enable <= reg_wdata[`LTAL_IRQ_W-1:0];
        default: irq_enable <= irq_enable;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags, conversion ready and alert state; set wins over clear
  always @(posedge clk)
  begin
    if (reset)
    begin
      flag_high <= 1'b0;
      flag_low <= 1'b0;
      conv_ready <= 1'b0;
      alert_active <= 1'b0;
    end
    else
    begin
      // clears first, so a conversion in the same cycle overrides them
      if (ready_clear)
        conv_ready <= 1'b0;
      if (flag_clear)
      begin
        flag_high <= 1'b0;
        flag_low <= 1'b0;
        alert_active <= 1'b0;
      end
      if (resp_take || eoc_clear)
        alert_active <= 1'b0;
      // conversion outcomes; shutdown writes touch nothing here
      if (conv_done)
      begin
        conv_ready <= 1'b1;
        if (eoc_mode)
          alert_active <= 1'b1;
        // latched mode only ever sets here; reads and the alert response do the clearing
        if (latch_mode)
        begin
          if (high_hit)
          begin
            flag_high <= 1'b1;
            alert_active <= 1'b1;
          end
          if (low_hit)
          begin
            flag_low <= 1'b1;
            alert_active <= 1'b1;
          end
        end
        else
        begin
          if (high_hit)
          begin
            flag_high <= 1'b1;
            flag_low <= 1'b0;
            alert_active <= 1'b1;
          end
          else if (low_hit)
          begin
            flag_low <= 1'b1;
            flag_high <= 1'b0;
            alert_active <= eoc_mode;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status: sticky, write-one-to-clear, set wins
  wire [`LTAL_IRQ_W-1:0] irq_set = {conv_done, low_hit, high_hit};
  wire [`LTAL_IRQ_W-1:0] irq_clr = (reg_write && reg_addr == `LTAL_OFS_IRQ_CLEAR) ?
    reg_wdata[`LTAL_IRQ_W-1:0] : {`LTAL_IRQ_W{1'b0}};
  genvar gi;
  generate
    for (gi = 0; gi < `LTAL_IRQ_W; gi = gi + 1)
    begin : g_irq
      always @(posedge clk)
      begin
        if (reset)
          irq_status[gi] <= 1'b0;
        else if (irq_set[gi])
          irq_status[gi] <= 1'b1;
        else if (irq_clr[gi])
          irq_status[gi] <= 1'b0;
      end
    end
  endgenerate
  // level output: drops once software clears or masks the bit
  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; config shows pre-clear status
  // idle cycles return zero so stale data never lingers on the port
  always @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 16'h0000;
    else if (reg_read)
    begin
      case (reg_addr)
        `LTAL_OFS_CONFIG: reg_rdata <= {config_bits[15:8], conv_ready, flag_high,
          flag_low, config_bits[4:0]};
        `LTAL_OFS_HIGH_LIMIT: reg_rdata <= high_limit;
        `LTAL_OFS_LOW_LIMIT: reg_rdata <= low_limit;
        `LTAL_OFS_IRQ_STATUS: reg_rdata <= {13'h0000, irq_status};
        `LTAL_OFS_IRQ_ENABLE: reg_rdata <= {13'h0000, irq_enable};
        `LTAL_OFS_RESULT: reg_rdata <= {pin_sync, last_result[14:0]};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // open-drain pin: pull low when active and sense 0, or inactive and sense 1
  // the released level itself comes from the pull-up outside
  assign alert_pin_oe = alert_active ^ sense_sel;
  assign alert_pin_out = 1'b0;

endmodule

// >>> testbench/ltal_alert_chk.sv
// ltal_alert_chk.sv: port-level assertions for the threshold alert logic
// assumes a bind to ltal_alert; config bits are shadowed from register writes
`timescale 1ns/100ps
module ltal_alert_chk (
  input wire clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [15:0] reg_rdata,
  input wire conv_done,
  input wire alert_resp_pin,
  input wire alert_pin_oe
);
  reg lat;
  reg sense;
  reg eoc;
  // config accesses that no conversion races with
  wire cfg_rd = reg_read && reg_addr == 4'h0 && !conv_done;
  wire cfg_wr = reg_write && reg_addr == 4'h0 && !conv_done;
  // shadow of mode bits; they only move through writes
  always @(posedge clk)
  begin
    if (reset)
    begin
      lat <= 1'b1;
      sense <= 1'b0;
      eoc <= 1'b0;
    end
    else if (reg_write)
    begin
      if (reg_addr == 4'h0)
      begin
        lat <= reg_wdata[4];
        sense <= reg_wdata[3];
      end
      if (reg_addr == 4'h2)
        eoc <= reg_wdata[15:14] == 2'b11;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_ready_once;
    cfg_rd ##1 cfg_rd |=> !reg_rdata[7];
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready seen twice");
  property p_read_clears;
    lat && cfg_rd ##1 cfg_rd |=> reg_rdata[6:5] == 2'b00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags kept");
  property p_conv_ready;
    conv_done ##1 cfg_rd |=> reg_rdata[7];
  endproperty
  a_conv_ready: assert property (p_conv_ready) else $error("ready not set");
  property p_resp_release;
    lat && $rose(alert_resp_pin) |-> ##[1:6] (alert_pin_oe == sense);
  endproperty
  a_resp_release: assert property (p_resp_release) else $error("alert held");
  property p_shut_keep;
    lat && cfg_wr && reg_wdata[4] && reg_wdata[10:9] == 2'b00 && reg_wdata[3] == sense
      |=> $stable(alert_pin_oe);
  endproperty
  a_shut_keep: assert property (p_shut_keep) else $error("pin moved");
  property p_run_keep;
    lat && cfg_wr && reg_wdata[4] && reg_wdata[10:9] != 2'b00 && reg_wdata[3] == sense
      |=> $stable(alert_pin_oe);
  endproperty
  a_run_keep: assert property (p_run_keep) else $error("pin moved");
  property p_sense_flip;
    cfg_wr && !eoc && reg_wdata[4] == lat && reg_wdata[3] != sense
      |=> alert_pin_oe != $past(alert_pin_oe);
  endproperty
  a_sense_flip: assert property (p_sense_flip) else $error("pin not inverted");
  property p_trans_hold;
    !lat && !eoc && !conv_done && !(reg_write && reg_addr == 4'h0) |=> $stable(alert_pin_oe);
  endproperty
  a_trans_hold: assert property (p_trans_hold) else $error("pin moved");
endmodule
bind ltal_alert ltal_alert_chk ltal_alert_chk_i (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .conv_done(conv_done),
  .alert_resp_pin(alert_resp_pin), .alert_pin_oe(alert_pin_oe));

// >>> testbench/ltal_host.sv
// ltal_host.sv: far side model: alert line pull-up and alert response pin
// assumes the design raises alert_pin_oe to pull the shared line low
`timescale 1ns/100ps
module ltal_host (
  input wire clk,
  input wire alert_pin_out,
  input wire alert_pin_oe,
  output wire alert_pin_in,
  output reg alert_resp_pin
);
  // pull-up holds the line high whenever the device lets go
  assign alert_pin_in = alert_pin_oe ? alert_pin_out : 1'b1;
  initial alert_resp_pin = 1'b0;
  // one alert response, held for one 160 ns link period
  task respond;
  begin
    @(posedge clk);
    alert_resp_pin <= 1'b1;
    repeat (8) @(posedge clk);
    alert_resp_pin <= 1'b0;
  end
  endtask
endmodule

// >>> testbench/test_light_threshold_alert_logic.sv
// test_light_threshold_alert_logic.sv: self-checking bench for ltal_alert
// assumes register offsets 0..6 and config layout as set by the designer
`timescale 1ns/100ps
module test_light_threshold_alert_logic;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg conv_done = 1'b0;
  reg [15:0] conv_result = 16'h0;
  wire [15:0] reg_rdata;
  wire alert_resp_pin, alert_pin_out, alert_pin_oe, alert_pin_in, irq;
  integer err_count = 0;
  integer cmp_count = 0;
  always #10 clk = ~clk;
  ltal_alert ltal_alert_i (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_result(conv_result),
    .alert_resp_pin(alert_resp_pin), .alert_pin_out(alert_pin_out),
    .alert_pin_oe(alert_pin_oe), .alert_pin_in(alert_pin_in), .irq(irq));
  ltal_host ltal_host_i (.clk(clk), .alert_pin_out(alert_pin_out),
    .alert_pin_oe(alert_pin_oe), .alert_pin_in(alert_pin_in),
    .alert_resp_pin(alert_resp_pin));
  task chk(input [15:0] g, input [15:0] e);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] v);
  begin
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
  end
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input [3:0] a, input [15:0] e);
  begin
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  end
  endtask
  task cv(input [15:0] v);
  begin
    @(posedge clk);
    conv_done <= 1'b1;
    conv_result <= v;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
  end
  endtask
  // conversion, then two back-to-back config reads: ready shows only once
  task cvrd(input [15:0] v, input [15:0] e1, input [15:0] e2);
  begin
    @(posedge clk);
    conv_done <= 1'b1;
    conv_result <= v;
    @(posedge clk);
    conv_done <= 1'b0;
    reg_read <= 1'b1;
    reg_addr <= 4'h0;
    @(posedge clk);
    #1 chk(reg_rdata, e1);
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e2);
  end
  endtask
  task pin(input e);
  begin
    #1 chk({15'h0, alert_pin_in}, {15'h0, e});
  end
  endtask
  task t_latched;
  begin
    rd(4'h0, 16'h0010);
    rd(4'hf, 16'h0000);
    wr(4'h1, 16'd100);
    wr(4'h2, 16'd10);
    wr(4'h0, 16'h0211);
    cv(16'd200);
    cv(16'd50);
    cv(16'd200);
    pin(1'b1);
    cv(16'd200);
    pin(1'b0);
    rd(4'h0, 16'h02d1);
    pin(1'b1);
    rd(4'h0, 16'h0211);
    cvrd(16'd200, 16'h02d1, 16'h0211);
    pin(1'b1);
  end
  endtask
  task t_resp;
  begin
    cv(16'd5);
    cv(16'd5);
    pin(1'b0);
    ltal_host_i.respond;
    repeat (4) @(posedge clk);
    pin(1'b1);
    rd(4'h0, 16'h02b1);
  end
  endtask
  task t_writes;
  begin
    cv(16'd200);
    cv(16'd200);
    wr(4'h0, 16'h0011);
    pin(1'b0);
    rd(4'h0, 16'h00d1);
    wr(4'h0, 16'h0211);
    cv(16'd200);
    cv(16'd200);
    wr(4'h0, 16'h0211);
    pin(1'b0);
    rd(4'h0, 16'h0251);
  end
  endtask
  task t_transparent;
  begin
    wr(4'h0, 16'h0200);
    cv(16'd200);
    pin(1'b0);
    rd(4'h0, 16'h02c0);
    rd(4'h0, 16'h0240);
    ltal_host_i.respond;
    repeat (4) @(posedge clk);
    pin(1'b0);
    cv(16'd5);
    pin(1'b1);
    rd(4'h0, 16'h02a0);
    wr(4'h0, 16'h0208);
    pin(1'b0);
  end
  endtask
  task t_irq;
  begin
    wr(4'h4, 16'h0007);
    wr(4'h5, 16'h0004);
    cv(16'd50);
    #1 chk({15'h0, irq}, 16'h0001);
    rd(4'h3, 16'h0004);
    wr(4'h5, 16'h0000);
    #1 chk({15'h0, irq}, 16'h0000);
    wr(4'h4, 16'h0004);
    rd(4'h3, 16'h0000);
    rd(4'h4, 16'h0000);
  end
  endtask
  task t_eoc;
  begin
    wr(4'h1, 16'hffff);
    wr(4'h2, 16'hc000);
    cv(16'hd000);
    pin(1'b1);
    rd(4'h0, 16'h02a8);
    pin(1'b0);
    repeat (3) @(posedge clk);
    rd(4'h6, 16'h5000);
  end
  endtask
  task print_verdict;
  begin
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_latched;
    t_resp;
    t_writes;
    t_transparent;
    t_irq;
    t_eoc;
    print_verdict;
  end
endmodule
